/* verilog/cyclic_sense_wake_timers.sv */
// Two cyclic timers driving high-side switches, wake pin sampling and
// cyclic wake events, with an AHB-Lite register slave.
// Assumes mode, fault and sleep request come from logic on hclk.
//
// What this block does
// - Timers periodically switch on mapped high-side drivers using their setup.
// - Sampled wake change pulls interrupt low, or requests restart from sleep.
// - Writing a nonzero on-time starts the timer regardless of other setup.
// - Off-low and off-high settings fix driver level before cycling starts.
// - Configuration error flag sets whenever on-time exceeds period.
// - First sample is only a reference; later differing samples cause wakes.
// - A 16 us stability filter follows each on-time before a wake counts.
// - Each wake pin has its own cyclic-sense wake flag.
// - In normal or stop, level status of cyclic-sense pins shows sampled levels only; other pins show the live level.
// - Fail-safe disables cycled switches and returns pins to static sense.
// - Faults disable the affected switch; timers keep running.
// - Sleep wake or sleep request with flags set requests restart.
// - Timers enabled as wake sources raise interrupts in normal and stop.
// - Every on-time start except the first raises the cyclic wake event.
// - Any timer may drive any high-side switch through the map registers.
// - Seven selectable periods from 10 ms to 2 s.
// - Five on-times plus off-high and off-low settings.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module cyclic_sense_wake_timers
  import cyclic_wake_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device state
  input wire mode_type mode,
  input wire logic sleep_request,
  input wire logic [HS_COUNT-1:0] hs_fault,
  // Wake pins and switches
  input wire logic [PIN_COUNT-1:0] wake_pin_x,
  output logic [HS_COUNT-1:0] high_side_switch_x,
  output logic [PIN_COUNT-1:0] pin_static_sense,
  // System signalling
  output logic int_n,
  output logic restart_request
);

  state_type st;
  state_type nx;
  logic tick;
  logic active_mode;
  logic [PIN_COUNT-1:0] pin_set;
  logic [PIN_COUNT-1:0] pin_cyc;
  logic [PIN_COUNT-1:0] clr_a;
  logic [TIMER_COUNT-1:0] tmr_set;
  logic [TIMER_COUNT-1:0] cfg_set;
  logic [TIMER_COUNT-1:0] on_end;
  logic [TIMER_COUNT-1:0] filt_done;
  logic [TIMER_COUNT-1:0] clr_b;
  logic [TIMER_COUNT-1:0] clr_c;
  logic [TIMER_COUNT-1:0][15:0] per_t;
  logic [TIMER_COUNT-1:0][15:0] on_t;
  logic [TIMER_COUNT-1:0] tmr_level;
  logic [31:0] wdat;
  logic tsel;

  function automatic logic [31:0] read_reg(input state_type s,
                                           input logic [31:0] a);
    logic [31:0] r;
    r = '0;
    if (a[31:8] == 24'h0) begin
      case (a[7:0])
        FIRST_TIMER_SETUP_OFS: begin
          r[SETUP_ON_LSB +: 3] = s.setup[0].on_sel;
          r[2:0] = s.setup[0].period_sel;
        end
        SECOND_TIMER_SETUP_OFS: begin
          r[SETUP_ON_LSB +: 3] = s.setup[1].on_sel;
          r[2:0] = s.setup[1].period_sel;
        end
        HIGH_SIDE_MAP_A_OFS: begin
          r[1:0] = s.hs_map[0];
          r[MAP_STRIDE +: 2] = s.hs_map[1];
        end
        HIGH_SIDE_MAP_B_OFS: begin
          r[1:0] = s.hs_map[2];
          r[MAP_STRIDE +: 2] = s.hs_map[3];
        end
        WAKE_SOURCE_ENABLE_OFS: begin
          r[TIMER_COUNT-1:0] = s.tmr_wake_en;
          r[PIN_EN_LSB +: PIN_COUNT] = s.pin_en;
          r[PIN_TIMER_LSB +: PIN_COUNT] = s.pin_timer;
        end
        WAKE_FLAGS_A_OFS: r[PIN_COUNT-1:0] = s.pin_flags;
        WAKE_FLAGS_B_OFS: r[TIMER_COUNT-1:0] = s.tmr_flags;
        WAKE_PIN_LEVELS_OFS: r[PIN_COUNT-1:0] = s.levels;
        TIMER_STATUS_OFS: begin
          r[TIMER_COUNT-1:0] = s.cfg_err;
          r[RUN_LSB +: TIMER_COUNT] = s.run;
        end
        default: r = '0;
      endcase
    end
    read_reg = r;
  endfunction : read_reg

  always_comb begin
    nx = st;
    wdat = hwdata;
    nx.sync1 = wake_pin_x;
    nx.sync2 = st.sync1;
    active_mode = (mode == mode_normal) || (mode == mode_stop);
    pin_set = '0;
    tmr_set = '0;
    on_end = '0;
    filt_done = '0;
    clr_a = '0;
    clr_b = '0;
    clr_c = '0;
    tsel = 1'b0;
    tick = (st.presc == 16'(TICK_CYCLES_P - 1));
    nx.presc = tick ? 16'h0 : st.presc + 16'h1;
    for (int t = 0; t < TIMER_COUNT; t++) begin
      per_t[t] = period_ticks(st.setup[t].period_sel);
      on_t[t] = on_ticks(st.setup[t].on_sel);
      cfg_set[t] = on_t[t] > per_t[t];
      // period and on-time counting; keeps running on faults
      if (st.run[t] && tick) begin
        if (st.tcnt[t] == per_t[t] - 16'h1) begin
          nx.tcnt[t] = 16'h0;
          // event at each later on-time start
          tmr_set[t] = st.tmr_wake_en[t] && active_mode;
        end else begin
          nx.tcnt[t] = st.tcnt[t] + 16'h1;
        end
        on_end[t] = (st.tcnt[t] + 16'h1 == on_t[t]);
      end
      if (st.filt_act[t]) begin
        nx.filt_stable[t] = st.filt_stable[t] & ~(st.sync2 ^ st.filt_val[t]);
        if (st.filt_cnt[t] == 12'(FILTER_CYCLES - 1)) begin
          nx.filt_act[t] = 1'b0;
          filt_done[t] = 1'b1;
        end else begin
          nx.filt_cnt[t] = st.filt_cnt[t] + 12'h1;
        end
      end
      if (on_end[t]) begin
        nx.filt_act[t] = 1'b1;
        nx.filt_cnt[t] = 12'h0;
        nx.filt_val[t] = st.sync2;
        nx.filt_stable[t] = '1;
      end
      // level of a running timer, or of an idle or off timer
      if (st.run[t]) begin
        tmr_level[t] = st.tcnt[t] < on_t[t];
      end else begin
        tmr_level[t] = st.setup[t].on_sel == ON_OFF_HIGH;
      end
    end
    for (int p = 0; p < PIN_COUNT; p++) begin
      tsel = st.pin_timer[p];
      pin_cyc[p] = st.pin_en[p] && st.run[tsel];
      if (filt_done[tsel] && st.pin_en[p] && nx.filt_stable[tsel][p]) begin
        // first sample only sets the reference
        if (st.has_ref[p] && st.ref_level[p] != st.filt_val[tsel][p]) begin
          pin_set[p] = 1'b1;
        end
        nx.ref_level[p] = st.filt_val[tsel][p];
        nx.has_ref[p] = 1'b1;
        nx.levels[p] = st.filt_val[tsel][p];
      end else if (!pin_cyc[p]) begin
        nx.levels[p] = st.sync2[p];
      end
    end
    // Register writes in the data phase
    if (st.a_pend && st.a_write) begin
      case (st.a_addr)
        FIRST_TIMER_SETUP_OFS, SECOND_TIMER_SETUP_OFS: begin
          tsel = st.a_addr[2];
          nx.setup[tsel].on_sel = wdat[SETUP_ON_LSB +: 3];
          nx.setup[tsel].period_sel = wdat[2:0];
          // a real on-time starts the timer at once
          nx.run[tsel] = on_ticks(wdat[SETUP_ON_LSB +: 3]) != 16'h0;
          nx.tcnt[tsel] = 16'h0;
          nx.filt_act[tsel] = 1'b0;
          for (int p = 0; p < PIN_COUNT; p++) begin
            if (st.pin_timer[p] == tsel) begin
              nx.has_ref[p] = 1'b0;
            end
          end
        end
        HIGH_SIDE_MAP_A_OFS: begin
          nx.hs_map[0] = wdat[1:0];
          nx.hs_map[1] = wdat[MAP_STRIDE +: 2];
        end
        HIGH_SIDE_MAP_B_OFS: begin
          nx.hs_map[2] = wdat[1:0];
          nx.hs_map[3] = wdat[MAP_STRIDE +: 2];
        end
        WAKE_SOURCE_ENABLE_OFS: begin
          nx.tmr_wake_en = wdat[TIMER_COUNT-1:0];
          nx.pin_en = wdat[PIN_EN_LSB +: PIN_COUNT];
          nx.pin_timer = wdat[PIN_TIMER_LSB +: PIN_COUNT];
        end
        WAKE_FLAGS_A_OFS: clr_a = wdat[PIN_COUNT-1:0];
        WAKE_FLAGS_B_OFS: clr_b = wdat[TIMER_COUNT-1:0];
        TIMER_STATUS_OFS: clr_c = wdat[TIMER_COUNT-1:0];
        default: clr_a = '0;
      endcase
    end
    if (mode == mode_fail_safe) begin
      nx.run = '0;
      nx.filt_act = '0;
    end
    // Sticky flags, a set beats a clear
    nx.pin_flags = (st.pin_flags & ~clr_a) | pin_set;
    nx.tmr_flags = (st.tmr_flags & ~clr_b) | tmr_set;
    nx.cfg_err = (st.cfg_err & ~clr_c) | cfg_set;
    nx.int_n = !(active_mode && ((|nx.pin_flags) || (|nx.tmr_flags)));
    // restart on sleep wake or on sleep request with pending flags
    nx.restart = ((mode == mode_sleep) && (|pin_set)) ||
                 (sleep_request && ((|st.pin_flags) || (|st.tmr_flags)));
    for (int h = 0; h < HS_COUNT; h++) begin
      case (st.hs_map[h])
        MAP_ON: nx.hs_drive[h] = 1'b1;
        MAP_TIMER1: nx.hs_drive[h] = tmr_level[0];
        MAP_TIMER2: nx.hs_drive[h] = tmr_level[1];
        default: nx.hs_drive[h] = 1'b0;
      endcase
      // fault shuts the switch; fail-safe shuts all
      if (hs_fault[h] || mode == mode_fail_safe) begin
        nx.hs_drive[h] = 1'b0;
      end
    end
    // static sensing outside active cyclic sense
    nx.static_sense = (mode == mode_fail_safe) ? '1 : ~pin_cyc;
    // AHB address phase; read data reflects this cycle's write
    if (hready) begin
      nx.a_pend = hsel && htrans[1];
      nx.a_write = hwrite;
      nx.a_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
      if (hsel && htrans[1] && !hwrite) begin
        nx.hrdata = read_reg(nx, haddr);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= STATE_RESET;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign high_side_switch_x = st.hs_drive;
  assign pin_static_sense = st.static_sense;
  assign int_n = st.int_n;
  assign restart_request = st.restart;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_filter_start;
    !st.filt_act[0] ##1 st.filt_act[0];
  endsequence

  sequence s_sleep_with_flags;
    ce && sleep_request && ((|st.pin_flags) || (|st.tmr_flags));
  endsequence

  a_fault_switch_off: assert property (
    ce && hs_fault[0] |=> !high_side_switch_x[0])
    else $error("switch stayed on during fault");
  a_failsafe_static: assert property (
    ce && mode == mode_fail_safe |=>
      pin_static_sense == '1 && high_side_switch_x == '0)
    else $error("fail-safe did not release cyclic sense");
  a_cfg_error_flag: assert property (
    ce && cfg_set[0] |=> st.cfg_err[0])
    else $error("config error not flagged");
  a_flag_interrupt: assert property (
    ce && active_mode ##1 (|st.pin_flags) |-> !int_n)
    else $error("interrupt not raised for wake flag");
  a_sleep_quiet: assert property (
    ce && mode == mode_sleep |=> int_n)
    else $error("interrupt pulled low in sleep");
  a_sleep_wake: assert property (
    ce && mode == mode_sleep && (|pin_set) |=> restart_request)
    else $error("no restart for wake in sleep");
  a_sleep_restart: assert property (
    s_sleep_with_flags |=> restart_request)
    else $error("no restart for sleep with flags set");
  a_timer_start: assert property (
    $rose(st.run[0]) |-> st.tcnt[0] == 16'h0 && on_t[0] != 16'h0)
    else $error("timer started badly");
  a_first_reference: assert property (
    $rose(st.pin_flags[0]) |-> $past(st.has_ref[0]))
    else $error("wake flagged without reference");
  a_filter_window: assert property (
    s_filter_start |-> st.filt_act[0] [*8])
    else $error("filter window cut short");
  a_cyclic_wake: assert property (
    ce && tmr_set[0] |=> st.tmr_flags[0] && !int_n)
    else $error("cyclic wake event lost");
  a_second_wake: assert property (
    ce && tmr_set[1] |=> st.tmr_flags[1] && !int_n)
    else $error("second timer wake event lost");
  a_enable_freeze: assert property (
    !ce |=> $stable(st))
    else $error("state moved while enable low");
  a_sampled_levels: assert property (
    ce && pin_cyc[0] && !filt_done[st.pin_timer[0]] |=> $stable(st.levels[0]))
    else $error("level status followed live pin");

endmodule : cyclic_sense_wake_timers

`default_nettype wire

/* verilog/cyclic_wake_pkg.sv */
// Constants, types and decoders for the cyclic sense and cyclic wake timers.
// Assumes a 125 MHz bus clock; tick and filter times become cycle counts here, periods and on-times become tick counts.
package cyclic_wake_pkg;

  localparam int HS_COUNT = 4;
  localparam int PIN_COUNT = 3;
  localparam int TIMER_COUNT = 2;

  // Clock and time base
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (TICK_US * 1000 + CLOCK_PERIOD_NS - 1) /
                               CLOCK_PERIOD_NS;
  // Wake filter window after each on-time
  localparam int FILTER_US = 16;
  localparam int FILTER_CYCLES = (FILTER_US * 1000 + CLOCK_PERIOD_NS - 1) /
                                 CLOCK_PERIOD_NS;

  // Period choices 10/20/50/100/200 ms, 1 s, 2 s; code 7 acts as 2 s
  localparam int PERIOD_US [8] = '{10000, 20000, 50000, 100000, 200000,
                                   1000000, 2000000, 2000000};
  // On-time choices 0.1/0.3/1/10/20 ms; other codes are off settings
  localparam int ON_US [8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;

  // Register byte offsets
  localparam logic [7:0] FIRST_TIMER_SETUP_OFS = 8'h00;
  localparam logic [7:0] SECOND_TIMER_SETUP_OFS = 8'h04;
  localparam logic [7:0] HIGH_SIDE_MAP_A_OFS = 8'h08;
  localparam logic [7:0] HIGH_SIDE_MAP_B_OFS = 8'h0c;
  localparam logic [7:0] WAKE_SOURCE_ENABLE_OFS = 8'h10;
  localparam logic [7:0] WAKE_FLAGS_A_OFS = 8'h14;
  localparam logic [7:0] WAKE_FLAGS_B_OFS = 8'h18;
  localparam logic [7:0] WAKE_PIN_LEVELS_OFS = 8'h1c;
  localparam logic [7:0] TIMER_STATUS_OFS = 8'h20;

  // Field positions
  localparam int SETUP_ON_LSB = 4;
  localparam int MAP_STRIDE = 4;
  localparam int PIN_EN_LSB = 4;
  localparam int PIN_TIMER_LSB = 8;
  localparam int RUN_LSB = 4;

  // High-side map codes
  localparam logic [1:0] MAP_OFF = 2'h0;
  localparam logic [1:0] MAP_ON = 2'h1;
  localparam logic [1:0] MAP_TIMER1 = 2'h2;
  localparam logic [1:0] MAP_TIMER2 = 2'h3;

  typedef enum logic [1:0] {
    mode_normal, mode_stop, mode_sleep, mode_fail_safe
  } mode_type;

  typedef struct packed {
    logic [2:0] on_sel;
    logic [2:0] period_sel;
  } setup_type;

  typedef struct packed {
    setup_type [TIMER_COUNT-1:0] setup;
    logic [HS_COUNT-1:0][1:0] hs_map;
    logic [TIMER_COUNT-1:0] tmr_wake_en;
    logic [PIN_COUNT-1:0] pin_en;
    logic [PIN_COUNT-1:0] pin_timer;
    logic [PIN_COUNT-1:0] pin_flags;
    logic [TIMER_COUNT-1:0] tmr_flags;
    logic [TIMER_COUNT-1:0] cfg_err;
    logic [PIN_COUNT-1:0] levels;
    logic [PIN_COUNT-1:0] ref_level;
    logic [PIN_COUNT-1:0] has_ref;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [15:0] presc;
    logic [TIMER_COUNT-1:0] run;
    logic [TIMER_COUNT-1:0][15:0] tcnt;
    logic [TIMER_COUNT-1:0] filt_act;
    logic [TIMER_COUNT-1:0][11:0] filt_cnt;
    logic [TIMER_COUNT-1:0][PIN_COUNT-1:0] filt_val;
    logic [TIMER_COUNT-1:0][PIN_COUNT-1:0] filt_stable;
    logic [HS_COUNT-1:0] hs_drive;
    logic [PIN_COUNT-1:0] static_sense;
    logic int_n;
    logic restart;
    logic a_pend;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
  } state_type;

  localparam state_type STATE_RESET = '{int_n: 1'b1, default: '0};

  function automatic logic [15:0] period_ticks(input logic [2:0] sel);
    period_ticks = 16'(PERIOD_US[sel] / TICK_US);
  endfunction : period_ticks

  function automatic logic [15:0] on_ticks(input logic [2:0] sel);
    on_ticks = 16'(ON_US[sel] / TICK_US);
  endfunction : on_ticks

endpackage : cyclic_wake_pkg

/* dv/wake_network_model.sv */
// Behavioural switch network fed by one high-side switch onto wake pins.
// Assumes a pull-down on each pin and a short RC hold after supply drops.
`timescale 1ns/100ps
`default_nettype none

module wake_network_model #(
  parameter int HOLD_CYCLES = 2100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply and contacts
  input wire logic supply,
  input wire logic [2:0] contact,
  // Wake pins
  output logic [2:0] pins
);
  logic [2:0] held_reg;
  int hold_cnt;

  // Hold the last powered level, then fall to the pull-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= '0;
      hold_cnt <= 0;
    end else if (supply) begin
      held_reg <= contact;
      hold_cnt <= HOLD_CYCLES;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end

  assign pins = supply ? contact : ((hold_cnt != 0) ? held_reg : 3'h0);
endmodule : wake_network_model

`default_nettype wire

/* dv/cyclic_sense_wake_timers_tb.sv */
// Self-checking bench for the cyclic sense and wake timers.
// Assumes the switch network model and a shortened 40-cycle time base.
`timescale 1ns/100ps
`default_nettype none

module cyclic_sense_wake_timers_tb;
  import cyclic_wake_pkg::*;
  localparam int TICK = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  mode_type mode = mode_normal;
  logic sleep_request = 1'b0;
  logic [HS_COUNT-1:0] hs_fault = '0;
  logic [PIN_COUNT-1:0] pins;
  logic [HS_COUNT-1:0] sw;
  logic [PIN_COUNT-1:0] pin_static_sense;
  logic int_n;
  logic restart_request;
  logic [2:0] contact = 3'h7;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int sw_hits;
  int int_hits;
  int rs_hits;
  logic [31:0] rd;
  // Register rows: address, write data, expected read
  logic [31:0] row_a [9] = '{32'h08, 32'h0c, 32'h10, 32'h04, 32'h04,
                             32'h24, 32'h08, 32'h0c, 32'h10};
  logic [31:0] row_w [9] = '{32'h33, 32'hffffffff, 32'hffffffff, 32'h06,
                             32'hff0f, 32'hffffffff, 32'h0, 32'h0, 32'h0};
  logic [31:0] row_e [9] = '{32'h33, 32'h33, 32'h773, 32'h06, 32'h07,
                             32'h0, 32'h0, 32'h0, 32'h0};

  always #4 hclk = ~hclk;

  cyclic_sense_wake_timers #(.TICK_CYCLES_P(TICK)) i_cyclic_sense_wake_timers (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode(mode), .sleep_request(sleep_request),
    .hs_fault(hs_fault), .wake_pin_x(pins), .high_side_switch_x(sw),
    .pin_static_sense(pin_static_sense), .int_n(int_n),
    .restart_request(restart_request)
  );

  wake_network_model i_wake_network_model (
    .clk(hclk), .rst_n(hresetn), .supply(sw[0]), .contact(contact),
    .pins(pins)
  );

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb_cycle(input logic [31:0] a, input logic wr,
                           input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready_seen() !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready_seen() !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb_cycle

  function automatic logic hready_seen();
    return hreadyout;
  endfunction : hready_seen

  // Run for n cycles, counting switch, interrupt and restart activity
  task automatic watch(input int n);
    sw_hits = 0;
    int_hits = 0;
    rs_hits = 0;
    repeat (n) begin
      @(negedge hclk);
      sw_hits += (sw[0] === 1'b1);
      int_hits += (int_n === 1'b0);
      rs_hits += (restart_request === 1'b1);
    end
  endtask : watch

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles > 60000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge hclk);
    check({26'h0, sw, int_n, restart_request}, 32'h2);
    hresetn <= 1'b1;
    repeat (3) @(negedge hclk);
    check({29'h0, pin_static_sense}, 32'h7);
    check({30'h0, hreadyout, hresp}, 32'h2);
    $display("Test reset done");
    for (int i = 0; i < 9; i++) begin
      ahb_cycle(row_a[i], 1'b1, row_w[i]);
      ahb_cycle(row_a[i], 1'b0, 32'h0);
      check(rd, row_e[i]);
    end
    $display("Test register rows done");
    ahb_cycle(32'h00, 1'b1, 32'h00);
    ahb_cycle(32'h08, 1'b1, 32'h02);
    watch(4);
    check(sw_hits, 0);
    ahb_cycle(32'h00, 1'b1, 32'h60);
    watch(4);
    check({31'h0, sw[0]}, 32'h1);
    ahb_cycle(32'h00, 1'b1, 32'h00);
    // pins set before period and on-time
    ahb_cycle(32'h10, 1'b1, 32'h010);
    ahb_cycle(32'h00, 1'b1, 32'h10);
    watch(9000);
    check({31'h0, sw_hits inside {[80:123]}}, 32'h1);
    check(int_hits, 0);
    contact <= 3'h0;
    watch(9000);
    check({31'h0, int_hits > 0}, 32'h1);
    ahb_cycle(32'h14, 1'b0, 32'h0);
    check(rd, 32'h1);
    ahb_cycle(32'h1c, 1'b0, 32'h0);
    check(rd & 32'h1, 32'h0);
    $display("Test cyclic sense done");
    @(posedge hclk);
    sleep_request <= 1'b1;
    @(posedge hclk);
    sleep_request <= 1'b0;
    watch(4);
    check(rs_hits, 1);
    ahb_cycle(32'h14, 1'b1, 32'h1);
    ahb_cycle(32'h14, 1'b0, 32'h0);
    check(rd, 32'h0);
    watch(2);
    check({31'h0, int_n}, 32'h1);
    @(posedge hclk);
    hs_fault <= 4'h1;
    watch(4100);
    check(sw_hits, 0);
    ahb_cycle(32'h20, 1'b0, 32'h0);
    check(rd & 32'h10, 32'h10);
    @(posedge hclk);
    hs_fault <= 4'h0;
    mode <= mode_fail_safe;
    watch(4100);
    check(sw_hits, 0);
    check({29'h0, pin_static_sense}, 32'h7);
    @(posedge hclk);
    mode <= mode_normal;
    $display("Test faults done");
    ahb_cycle(32'h00, 1'b1, 32'h50);
    ahb_cycle(32'h20, 1'b0, 32'h0);
    check(rd & 32'h1, 32'h1);
    ahb_cycle(32'h00, 1'b1, 32'h00);
    ahb_cycle(32'h20, 1'b1, 32'h3);
    ahb_cycle(32'h20, 1'b0, 32'h0);
    check(rd & 32'h3, 32'h0);
    // stop timers, enable source, then start
    ahb_cycle(32'h08, 1'b1, 32'h0);
    ahb_cycle(32'h04, 1'b1, 32'h00);
    ahb_cycle(32'h10, 1'b1, 32'h002);
    ahb_cycle(32'h18, 1'b1, 32'h3);
    ahb_cycle(32'h04, 1'b1, 32'h10);
    watch(3880);
    ahb_cycle(32'h18, 1'b0, 32'h0);
    check(rd, 32'h0);
    watch(250);
    ahb_cycle(32'h18, 1'b0, 32'h0);
    check(rd, 32'h2);
    check({31'h0, int_n}, 32'h0);
    $display("Test cyclic wake done");
    // Enable low freezes the running timer
    ahb_cycle(32'h18, 1'b1, 32'h2);
    @(posedge hclk);
    ce <= 1'b0;
    watch(4100);
    check(int_hits, 0);
    @(posedge hclk);
    ce <= 1'b1;
    ahb_cycle(32'h18, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("Test clock enable done");
    // level, map and pin before starting
    ahb_cycle(32'h00, 1'b1, 32'h00);
    ahb_cycle(32'h08, 1'b1, 32'h02);
    ahb_cycle(32'h10, 1'b1, 32'h010);
    ahb_cycle(32'h14, 1'b1, 32'h7);
    ahb_cycle(32'h18, 1'b1, 32'h3);
    ahb_cycle(32'h00, 1'b1, 32'h10);
    watch(4100);
    @(posedge hclk);
    mode <= mode_sleep;
    contact <= 3'h7;
    watch(8100);
    check(rs_hits, 1);
    check(int_hits, 0);
    ahb_cycle(32'h14, 1'b0, 32'h0);
    check(rd, 32'h1);
    @(posedge hclk);
    mode <= mode_stop;
    watch(2);
    check({31'h0, int_n}, 32'h0);
    $display("Test low power done");
    final_report();
  end
endmodule : cyclic_sense_wake_timers_tb

`default_nettype wire
